// File: core/dcc_consts.svh
// Purpose: offsets, field positions and reset values of the calibration control block
// Assumes: 8-bit registers on the documented register port
// Notes:   definitions only
`ifndef DCC_CONSTS_SVH
`define DCC_CONSTS_SVH

// register offsets
`define DCC_OFS_SERIAL_CTL   8'h00
`define DCC_OFS_DATA_CFG     8'h02
`define DCC_OFS_REVISION     8'h0D
`define DCC_OFS_CAL_STATE    8'h0E
`define DCC_OFS_MEM_CTL      8'h0F
`define DCC_OFS_COEF_ADDR    8'h10
`define DCC_OFS_COEF_DATA    8'h11

// reset values
`define DCC_RST_SERIAL_CTL   8'h80
`define DCC_RST_DATA_CFG     8'h00
`define DCC_RST_DIV_SEL      3'h0
`define DCC_RST_COEF_ADDR    6'h00
`define DCC_RST_COEF_DATA    6'h3F
// revision code, value is arbitrary
`define DCC_REVISION_CODE    4'h5
// uncalibrated coefficient value, mid scale
`define DCC_COEF_DEFAULT     6'h20

// field positions
`define DCC_BIT_REF_SEL      0
`define DCC_BIT_SW_RESET     5
`define DCC_BIT_CAL_CLK_EN   0
`define DCC_BIT_CLEAR        0
`define DCC_BIT_FETCH        2
`define DCC_BIT_STORE        3
`define DCC_BIT_START        6
`define DCC_BIT_DONE         7

// divider: ratio is this base shifted right by the select code
`define DCC_DIV_BASE         9'h100
// number of coefficient words
`define DCC_COEF_WORDS       64

`endif

// File: core/dcc_pkg.sv
// Purpose: shared types of the calibration control block
// Assumes: nothing beyond the constants header
// Notes:   sequencer states carry no explicit codes, the calibration set codes are explicit
package dcc_pkg;
    typedef logic [5:0] dcc_word_t;   // one coefficient
    typedef logic [5:0] dcc_addr_t;   // coefficient location
    typedef logic [2:0] dcc_div_t;    // divider select code

    // calibration set reported to software
    typedef enum logic [1:0] {
        DCC_SET_COEFFICIENT_CLEAR_BIT = 2'h0,
        DCC_SET_SELF  = 2'h1,
        DCC_SET_USER  = 2'h3
    } dcc_set_e;

    // self calibration sequencer
    typedef enum logic [0:0] {
        DCC_ENG_IDLE,
        DCC_ENG_RUN
    } dcc_eng_e;
endpackage

// File: core/dcc_cal_engine.sv
// Purpose: calibration clock divider and self calibration sequencer
// Assumes: start and sw_rst are one-cycle pulses
// Notes:   one coefficient is written per calibration clock tick
`timescale 1ns/100ps
`default_nettype none
`include "dcc_consts.svh"

module dcc_cal_engine (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             arst_n,
    // control
    input  wire logic             sw_rst,
    input  wire logic             start,
    input  wire logic             cal_clk_en,
    input  wire dcc_pkg::dcc_div_t div_sel,
    input  wire dcc_pkg::dcc_word_t trim_in,
    // results
    output logic                  busy_q,
    output logic                  tick_q,
    output logic                  wr_en_q,
    output dcc_pkg::dcc_addr_t    wr_addr_q,
    output dcc_pkg::dcc_word_t    wr_data_q,
    output logic                  done_q
);
    import dcc_pkg::*;

    logic [7:0]  div_cnt_q, div_cnt_d;   // divider count
    logic        tick_d;                 // calibration clock enable pulse
    dcc_eng_e    st_q, st_d;             // sequencer state
    dcc_addr_t   addr_d;                 // location shown with the write strobe
    dcc_addr_t   idx_q, idx_d;           // next location the sequence writes
    logic        wr_en_d, done_d;
    dcc_word_t   wr_data_d;
    logic [8:0]  ratio;                  // current divide ratio

    // divider: ratio 256 >> select, stopped while the enable bit is low
    always_comb begin
        ratio     = 9'(`DCC_DIV_BASE >> div_sel);
        div_cnt_d = div_cnt_q;
        tick_d    = 1'b0;
        if (sw_rst || !cal_clk_en) begin
            div_cnt_d = 8'h00;
        end else if ({1'b0, div_cnt_q} == ratio - 9'h001) begin
            div_cnt_d = 8'h00;
            tick_d    = 1'b1;
        end else begin
            div_cnt_d = div_cnt_q + 8'h01;
        end
    end

    // sequencer: walks every location once per start
    always_comb begin
        st_d      = st_q;
        addr_d    = wr_addr_q;
        idx_d     = idx_q;
        wr_en_d   = 1'b0;
        wr_data_d = trim_in;
        done_d    = 1'b0;
        unique case (st_q)
            DCC_ENG_IDLE: begin
                if (start && !sw_rst) begin
                    st_d   = DCC_ENG_RUN;
                    idx_d  = 6'h00;
                end
            end
            DCC_ENG_RUN: begin
                if (sw_rst) begin
                    st_d = DCC_ENG_IDLE;
                end else if (tick_d) begin
                    wr_en_d = 1'b1;
                    addr_d  = idx_q;
                    // last location ends the walk
                    if (idx_q == 6'h3F) begin
                        st_d   = DCC_ENG_IDLE;
                        done_d = 1'b1;
                    end else begin
                        idx_d = idx_q + 6'h01;
                    end
                end
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            div_cnt_q <= 8'h00;
            tick_q    <= 1'b0;
            st_q      <= DCC_ENG_IDLE;
            busy_q    <= 1'b0;
            wr_en_q   <= 1'b0;
            wr_addr_q <= 6'h00;
            idx_q     <= 6'h00;
            wr_data_q <= 6'h00;
            done_q    <= 1'b0;
        end else begin
            div_cnt_q <= div_cnt_d;
            tick_q    <= tick_d;
            st_q      <= st_d;
            busy_q    <= (st_d == DCC_ENG_RUN);
            wr_en_q   <= wr_en_d;
            // step counter kept apart from the strobe copy so no step is lost
            wr_addr_q <= addr_d;
            idx_q     <= idx_d;
            wr_data_q <= wr_data_d;
            done_q    <= done_d;
        end
    end
endmodule
`default_nettype wire

// File: core/dcc_top.sv
// Purpose: register bank for converter self calibration and coefficient memory
// Assumes: register port already deframed from the serial link, clk at 250 MHz
// Notes:   memory control bits are write-one pulses and read back as zero
`timescale 1ns/100ps
`default_nettype none
`include "dcc_consts.svh"

module dcc_top (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // register port
    input  wire logic              reg_wr_en,
    input  wire logic              reg_rd_en,
    input  wire logic [7:0]        reg_addr,
    input  wire logic [7:0]        reg_wdata,
    output logic [7:0]             reg_rdata_q,
    output logic                   reg_rvalid_q,
    // analog side
    input  wire dcc_pkg::dcc_word_t cal_trim_in,
    output logic                   ext_ref_sel_q,
    output logic                   cal_busy_q,
    output logic                   cal_tick_q
);
    import dcc_pkg::*;

    // register state
    logic [7:0]  serial_ctl_q, serial_ctl_d;  // serial control byte
    logic [7:0]  data_cfg_q, data_cfg_d;      // data configuration byte
    dcc_div_t    div_sel_q, div_sel_d;        // divider select
    dcc_set_e    cal_set_q, cal_set_d;        // active calibration set
    logic        done_q, done_d;              // calibration done flag
    dcc_addr_t   coef_addr_q, coef_addr_d;    // coefficient address
    dcc_word_t   coef_data_q, coef_data_d;    // coefficient data
    logic        sw_rst_q, sw_rst_d;          // software reset pulse
    logic        start_q, start_d;            // start pulse to engine
    logic [7:0]  rdata_d;
    // coefficient memory
    dcc_word_t   mem_q [`DCC_COEF_WORDS];
    dcc_word_t   mem_d [`DCC_COEF_WORDS];
    // decoded write strobes
    logic        wr_mem_ctl;
    logic        do_clear, do_store, do_fetch;
    // engine results
    logic        eng_busy, eng_tick, eng_wr, eng_done;
    dcc_addr_t   eng_addr;
    dcc_word_t   eng_data;

    // true when the address equals the given offset, whether or not a write is strobed
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        hit = (a == ofs);
    endfunction

    assign wr_mem_ctl = reg_wr_en && hit(reg_addr, `DCC_OFS_MEM_CTL);
    assign do_clear   = wr_mem_ctl && reg_wdata[`DCC_BIT_CLEAR];
    assign do_store   = wr_mem_ctl && reg_wdata[`DCC_BIT_STORE];
    assign do_fetch   = wr_mem_ctl && reg_wdata[`DCC_BIT_FETCH];

    // divider and self calibration sequencer
    dcc_cal_engine u_engine (
        .clk        (clk),
        .arst_n     (arst_n),
        .sw_rst     (sw_rst_q),
        .start      (start_q),
        .cal_clk_en (data_cfg_q[`DCC_BIT_CAL_CLK_EN]),
        .div_sel    (div_sel_q),
        .trim_in    (cal_trim_in),
        .busy_q     (eng_busy),
        .tick_q     (eng_tick),
        .wr_en_q    (eng_wr),
        .wr_addr_q  (eng_addr),
        .wr_data_q  (eng_data),
        .done_q     (eng_done)
    );

    // register writes and hardware updates
    always_comb begin
        serial_ctl_d = serial_ctl_q;
        data_cfg_d   = data_cfg_q;
        div_sel_d    = div_sel_q;
        cal_set_d    = cal_set_q;
        done_d       = done_q;
        coef_addr_d  = coef_addr_q;
        coef_data_d  = coef_data_q;
        sw_rst_d     = 1'b0;
        start_d      = 1'b0;
        if (sw_rst_q) begin
            // every register but the serial control byte returns to default, whose reset bit alone clears; the memory keeps its contents
            data_cfg_d  = `DCC_RST_DATA_CFG;
            div_sel_d   = `DCC_RST_DIV_SEL;
            cal_set_d   = DCC_SET_COEFFICIENT_CLEAR_BIT;
            done_d      = 1'b0;
            coef_addr_d = `DCC_RST_COEF_ADDR;
            coef_data_d = `DCC_RST_COEF_DATA;
            serial_ctl_d[`DCC_BIT_SW_RESET] = 1'b0;
        end else begin
            if (reg_wr_en) begin
                unique case (reg_addr)
                    `DCC_OFS_SERIAL_CTL: begin
                        serial_ctl_d = reg_wdata;
                        sw_rst_d     = reg_wdata[`DCC_BIT_SW_RESET];
                    end
                    `DCC_OFS_DATA_CFG: begin
                        data_cfg_d = reg_wdata;
                    end
                    `DCC_OFS_CAL_STATE: begin
                        div_sel_d = reg_wdata[2:0];
                    end
                    `DCC_OFS_MEM_CTL: begin
                        if (reg_wdata[`DCC_BIT_START]) begin
                            start_d = !eng_busy;
                            done_d  = 1'b0;
                        end
                    end
                    `DCC_OFS_COEF_ADDR: begin
                        coef_addr_d = reg_wdata[5:0];
                    end
                    `DCC_OFS_COEF_DATA: begin
                        coef_data_d = reg_wdata[5:0];
                    end
                    default: begin
                        // revision and unmapped offsets ignore writes
                    end
                endcase
            end
            // fetch wins over a plain data write in the same cycle
            if (do_fetch) begin
                coef_data_d = mem_q[coef_addr_q];
            end
            // which set is in use, by the last memory change
            if (do_clear) begin
                cal_set_d = DCC_SET_COEFFICIENT_CLEAR_BIT;
            end
            if (do_store) begin
                cal_set_d = DCC_SET_USER;
            end
            // completion sets the flag, winning over a clearing start
            if (eng_done) begin
                done_d    = 1'b1;
                cal_set_d = DCC_SET_SELF;
            end
        end
    end

    // coefficient memory next contents
    always_comb begin
        mem_d = mem_q;
        if (do_clear && !sw_rst_q) begin
            for (int i = 0; i < `DCC_COEF_WORDS; i++) begin
                mem_d[i] = `DCC_COEF_DEFAULT;
            end
        end
        if (do_store && !sw_rst_q) begin
            mem_d[coef_addr_q] = coef_data_q;
        end
        // engine result lands last so it wins a collision
        if (eng_wr) begin
            mem_d[eng_addr] = eng_data;
        end
    end

    // read mux, unmapped offsets return zero
    always_comb begin
        rdata_d = 8'h00;
        unique case (reg_addr)
            `DCC_OFS_SERIAL_CTL: rdata_d = serial_ctl_q;
            `DCC_OFS_DATA_CFG:   rdata_d = data_cfg_q;
            `DCC_OFS_REVISION:   rdata_d = {4'h0, `DCC_REVISION_CODE};
            `DCC_OFS_CAL_STATE:  rdata_d = {2'h0, cal_set_q, 1'b0, div_sel_q};
            `DCC_OFS_MEM_CTL:    rdata_d = {done_q, 7'h00};
            `DCC_OFS_COEF_ADDR:  rdata_d = {2'h0, coef_addr_q};
            `DCC_OFS_COEF_DATA:  rdata_d = {2'h0, coef_data_q};
            default:             rdata_d = 8'h00;
        endcase
    end

    // register bank flops
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            serial_ctl_q  <= `DCC_RST_SERIAL_CTL;
            data_cfg_q    <= `DCC_RST_DATA_CFG;
            div_sel_q     <= `DCC_RST_DIV_SEL;
            cal_set_q     <= DCC_SET_COEFFICIENT_CLEAR_BIT;
            done_q        <= 1'b0;
            coef_addr_q   <= `DCC_RST_COEF_ADDR;
            coef_data_q   <= `DCC_RST_COEF_DATA;
            sw_rst_q      <= 1'b0;
            start_q       <= 1'b0;
            reg_rdata_q   <= 8'h00;
            reg_rvalid_q  <= 1'b0;
            ext_ref_sel_q <= 1'b0;
            cal_busy_q    <= 1'b0;
            cal_tick_q    <= 1'b0;
        end else begin
            serial_ctl_q  <= serial_ctl_d;
            data_cfg_q    <= data_cfg_d;
            div_sel_q     <= div_sel_d;
            cal_set_q     <= cal_set_d;
            done_q        <= done_d;
            coef_addr_q   <= coef_addr_d;
            coef_data_q   <= coef_data_d;
            sw_rst_q      <= sw_rst_d;
            start_q       <= start_d;
            reg_rdata_q   <= reg_rd_en ? rdata_d : 8'h00;
            reg_rvalid_q  <= reg_rd_en;
            ext_ref_sel_q <= serial_ctl_d[`DCC_BIT_REF_SEL];
            cal_busy_q    <= eng_busy;
            cal_tick_q    <= eng_tick;
        end
    end

    // memory flops, uncalibrated after power up
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < `DCC_COEF_WORDS; i++) begin
                mem_q[i] <= `DCC_COEF_DEFAULT;
            end
        end else begin
            mem_q <= mem_d;
        end
    end
endmodule
`default_nettype wire

// File: tb/dcc_top_assertions.sv
// Purpose: port-level assertions for the calibration register bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   attached to dcc_top by bind at the foot of this file
`timescale 1ns/100ps
`default_nettype none
`include "dcc_consts.svh"

module dcc_checker (
    // clock and reset
    input wire logic              clk,
    input wire logic              arst_n,
    // register port
    input wire logic              reg_wr_en,
    input wire logic              reg_rd_en,
    input wire logic [7:0]        reg_addr,
    input wire logic [7:0]        reg_wdata,
    input wire logic [7:0]        reg_rdata_q,
    input wire logic              reg_rvalid_q,
    // analog side
    input wire dcc_pkg::dcc_word_t cal_trim_in,
    input wire logic              ext_ref_sel_q,
    input wire logic              cal_busy_q,
    input wire logic              cal_tick_q
);
    // every check sees the one clock and is off in reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // a read is answered on the next edge, and only a read is
    a_read_gets_answer: assert property (reg_rd_en |=> reg_rvalid_q)
        else $error("read not answered");
    a_answer_has_cause: assert property (reg_rvalid_q |-> $past(reg_rd_en))
        else $error("answer without read");
    a_idle_data_zero: assert property (!reg_rvalid_q |-> reg_rdata_q == 8'h00)
        else $error("read data not zero when idle");
    // fixed revision byte
    a_revision_fixed: assert property (reg_rd_en && reg_addr == 8'h0D |=>
        reg_rdata_q == {4'h0, `DCC_REVISION_CODE})
        else $error("revision byte wrong");
    // control pulses read back as zero
    a_ctl_bits_zero: assert property (reg_rd_en && reg_addr == 8'h0F |=>
        reg_rdata_q[6:0] == 7'h00)
        else $error("memory control reads nonzero low bits");
    // address and data are six bits wide
    a_coef_six_bits: assert property (reg_rd_en && reg_addr[7:1] == 7'h08 |=>
        reg_rdata_q[7:6] == 2'h0)
        else $error("coefficient byte has upper bits");
    // state field never shows the unused code
    a_state_code_ok: assert property (reg_rd_en && reg_addr == 8'h0E |=>
        reg_rdata_q[5:4] != 2'h2 && reg_rdata_q[7:6] == 2'h0 && !reg_rdata_q[3])
        else $error("state byte malformed");
    // reference select follows bit 0 of control writes only
    a_ref_follows: assert property (reg_wr_en && reg_addr == 8'h00 |=>
        ext_ref_sel_q == $past(reg_wdata[0]))
        else $error("reference select not written");
    a_ref_holds: assert property (!(reg_wr_en && reg_addr == 8'h00) |=>
        $stable(ext_ref_sel_q))
        else $error("reference select changed unasked");
    // fastest ratio is two, so ticks never touch
    a_tick_apart: assert property (cal_tick_q |=> !cal_tick_q)
        else $error("ticks back to back");

    // main scenarios
    c_done_read: cover property (reg_rvalid_q && reg_rdata_q[7]);
    c_tick_busy: cover property (cal_tick_q && cal_busy_q);
    c_ref_ext: cover property ($rose(ext_ref_sel_q));
endmodule

bind dcc_top dcc_checker chk_u (
    .clk          (clk),
    .arst_n       (arst_n),
    .reg_wr_en    (reg_wr_en),
    .reg_rd_en    (reg_rd_en),
    .reg_addr     (reg_addr),
    .reg_wdata    (reg_wdata),
    .reg_rdata_q  (reg_rdata_q),
    .reg_rvalid_q (reg_rvalid_q),
    .cal_trim_in  (cal_trim_in),
    .ext_ref_sel_q(ext_ref_sel_q),
    .cal_busy_q   (cal_busy_q),
    .cal_tick_q   (cal_tick_q)
);
`default_nettype wire

// File: tb/dcc_host_model.sv
// Purpose: register port host that issues single-byte reads and writes
// Assumes: strobes driven at the falling edge, taken at the rising edge
// Notes:   address and data are scrambled between transfers
`timescale 1ns/100ps
`default_nettype none

module dcc_host_model (
    // clock
    input  wire logic       clk,
    // requests toward the block
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic [7:0]      reg_addr,
    output logic [7:0]      reg_wdata,
    // answer from the block
    input  wire logic [7:0] reg_rdata_q,
    input  wire logic       reg_rvalid_q
);
    // idle port at time zero
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    // one write, strobe held for one edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr_en = 1'b1;
        reg_addr  = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr_en = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    // one read, answer sampled in the cycle after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk);
        reg_rd_en = 1'b1;
        reg_addr  = a;
        @(negedge clk);
        d         = reg_rdata_q;
        v         = reg_rvalid_q;
        reg_rd_en = 1'b0;
        reg_addr  = ~a;
    endtask
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// Purpose: self-checking bench for the calibration register bank
// Assumes: host model drives the register port, bench drives trim and reset
// Notes:   longest case is a full calibration at ratio 256
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import dcc_pkg::*;
    logic       clk = 1'b0;        // 250 MHz
    logic       arst_n = 1'b0;     // reset, active low
    wire logic  reg_wr_en;         // host write strobe
    wire logic  reg_rd_en;         // host read strobe
    wire logic [7:0] reg_addr;     // host offset
    wire logic [7:0] reg_wdata;    // host data
    logic [7:0] reg_rdata_q;       // read answer
    logic       reg_rvalid_q;      // read valid
    dcc_word_t  cal_trim_in = 6'h15; // trim from analog side
    logic       ext_ref_sel_q;     // reference choice
    logic       cal_busy_q;        // calibration running
    logic       cal_tick_q;        // calibration clock tick
    int         fail_count = 0;    // mismatches
    int         check_count = 0;   // comparisons
    int         cyc = 0;           // cycles run
    int         n;                 // scratch count
    logic [7:0] rv;                // read data
    logic       vv;                // read valid
    // reset table and divider codes
    localparam logic [7:0] RA[8] = '{8'h00, 8'h02, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11, 8'h05};
    localparam logic [7:0] RV[8] = '{8'h80, 8'h00, 8'h05, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h00};
    localparam logic [2:0] DC[4] = '{3'h0, 3'h1, 3'h6, 3'h7};

    always #2 clk = ~clk;

    dcc_host_model host_u (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q));
    dcc_top dut_u (.clk(clk), .arst_n(arst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
        .reg_rvalid_q(reg_rvalid_q), .cal_trim_in(cal_trim_in),
        .ext_ref_sel_q(ext_ref_sel_q), .cal_busy_q(cal_busy_q), .cal_tick_q(cal_tick_q));

    // verdict and end of run
    task automatic close_out;
        if (fail_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one comparison
    task automatic chk(input logic [8:0] g, input logic [8:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    // read one byte and compare it
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        host_u.rd(a, rv, vv);
        chk({8'h00, vv}, 9'h001);
        chk({1'b0, rv}, {1'b0, e});
    endtask

    // poll the done flag with a bound
    task automatic wait_done;
        for (int k = 0; k < 600; k++) begin
            host_u.rd(8'h0F, rv, vv);
            if (rv[7] === 1'b1)
                break;
            repeat (40) @(negedge clk);
        end
        chk({1'b0, rv}, 9'h080);
    endtask

    // cycles between two ticks
    task automatic tick_gap;
        int k;
        k = 0;
        while (cal_tick_q !== 1'b1 && k < 2000) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        n = 1;
        while (cal_tick_q !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            fail_count++;
            close_out();
        end
    end

    // main sequence
    initial begin
        repeat (20) @(negedge clk);
        arst_n = 1'b1;
        for (int i = 0; i < 8; i++)
            rdc(RA[i], RV[i]);
        chk({8'h00, ext_ref_sel_q}, 9'h000);
        host_u.wr(8'h0D, 8'hFF);
        rdc(8'h0D, 8'h05);
        host_u.wr(8'h00, 8'h81);
        chk({8'h00, ext_ref_sel_q}, 9'h001);
        // store, fetch, neighbour, clear
        host_u.wr(8'h10, 8'h05);
        host_u.wr(8'h11, 8'h2A);
        host_u.wr(8'h0F, 8'h08);
        rdc(8'h0E, 8'h30);
        host_u.wr(8'h11, 8'h00);
        host_u.wr(8'h0F, 8'h04);
        rdc(8'h11, 8'h2A);
        host_u.wr(8'h10, 8'h06);
        host_u.wr(8'h0F, 8'h04);
        rdc(8'h11, 8'h20);
        host_u.wr(8'h10, 8'h05);
        host_u.wr(8'h0F, 8'h01);
        host_u.wr(8'h0F, 8'h04);
        rdc(8'h11, 8'h20);
        rdc(8'h0E, 8'h00);
        // start with the calibration clock stopped
        host_u.wr(8'h0E, 8'h07);
        host_u.wr(8'h0F, 8'h40);
        n = 0;
        repeat (300) begin
            @(negedge clk);
            n += int'(cal_tick_q === 1'b1);
        end
        chk(n[8:0], 9'h000);
        host_u.wr(8'h02, 8'h01);
        wait_done();
        rdc(8'h0E, 8'h17);
        // every divider code in the table
        for (int i = 0; i < 4; i++) begin
            cal_trim_in = 6'h30 + 6'(i);
            host_u.wr(8'h0E, {5'h00, DC[i]});
            host_u.wr(8'h0F, 8'h40);
            rdc(8'h0F, 8'h00);
            tick_gap();
            chk(n[8:0], 9'h100 >> DC[i]);
            chk({8'h00, cal_busy_q}, 9'h001);
            wait_done();
            repeat (8) @(negedge clk);
            chk({8'h00, cal_busy_q}, 9'h000);
            host_u.wr(8'h10, 8'h3F);
            host_u.wr(8'h0F, 8'h04);
            rdc(8'h11, {2'h0, cal_trim_in});
        end
        // software reset spares the control byte but for its reset bit
        host_u.wr(8'h10, 8'h09);
        host_u.wr(8'h00, 8'hA1);
        repeat (3) @(negedge clk);
        rdc(8'h00, 8'h81);
        rdc(8'h10, 8'h00);
        rdc(8'h02, 8'h00);
        rdc(8'h0E, 8'h00);
        chk({8'h00, ext_ref_sel_q}, 9'h001);
        close_out();
    end
endmodule
`default_nettype wire
